/* File: design/converter_fault_latch_control.sv */
/*
 Converter fault-latch control: qualifies comparator flags, sequences soft start,
 holds the off latch and exposes status and interrupts over APB.
 Assumes comparator flags and the enable pin are asynchronous levels.
*/
// Summary of operation
// - Output-high check armed only with enable high and soft start past threshold.
// - Output-low check armed once soft start passes threshold; off while enable low.
// - Feedback high for 500 us continuously forces output low and latches.
// - Supply below lockout level gives standby except from the off latch; leave only after hysteresis recovery.
// - Timing-pin open or short for 500 us forces output low and latches.
// - Timing-pin check always active once supply start-up has completed.
// - Soft start not past threshold within 64 ms enters the off latch.
// - Every latching protection enters one off-latch state holding output low.
// - Host drives enable low once; device clears the latch on enable low.
// - Over-temperature flag forces converter output low while it stands.
// - Over-current ends high-side conduction within the same switching period.
// - Over-current limiting for 500 us continuously forces output low and latches.
`timescale 1ns/1ps
`default_nettype none
module converter_fault_latch_control (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins and comparator flags
    input wire logic enable_pin,
    input wire logic supply_ok,
    input wire logic soft_start_threshold,
    input wire logic feedback_high,
    input wire logic feedback_low,
    input wire logic timing_pin_open_short_fault,
    input wire logic overcurrent,
    input wire logic overtemp_shutdown,
    input wire logic pwm_period_start,
    input wire logic pwm_on_request,
    // Converter control
    output logic converter_run,
    output logic soft_start_run,
    output logic high_side_on,
    output logic irq
);
    localparam int NS = 9;

    logic [NS-1:0] raw_in;
    logic [NS-1:0] sync_in;
    assign raw_in = {pwm_on_request, pwm_period_start, overtemp_shutdown, overcurrent,
                     timing_pin_open_short_fault, feedback_low, feedback_high,
                     soft_start_threshold, enable_pin};

    sync2 #(.W(NS)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .d(raw_in),
        .q(sync_in)
    );

    // Supply comparator carries the hysteresis; its level is already the lockout state.
    logic supply_s;
    sync2 #(.W(1)) u_sync_supply (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .d(supply_ok),
        .q(supply_s)
    );

    wire en_s = sync_in[0];
    wire ss_s = sync_in[1];
    wire fb_high_s = sync_in[2];
    wire fb_low_s = sync_in[3];
    wire tpin_s = sync_in[4];
    wire oc_s = sync_in[5];
    wire ot_s = sync_in[6];
    wire period_s = sync_in[7];
    wire on_req_s = sync_in[8];

    fault_latch_pkg::seq_state_type state_reg;
    fault_latch_pkg::seq_state_type state_next;
    logic [fault_latch_pkg::CNT_W-1:0] ss_count_reg;
    logic [31:0] ctrl_reg;
    logic [fault_latch_pkg::EV_W-1:0] irq_stat_reg;
    logic [fault_latch_pkg::EV_W-1:0] irq_mask_reg;
    logic [fault_latch_pkg::EV_W-1:0] cause_reg;
    logic oc_cut_reg;
    logic [31:0] prdata_reg;

    wire in_run = (state_reg == fault_latch_pkg::ST_SOFTSTART) || (state_reg == fault_latch_pkg::ST_REGULATE);
    wire lockout = !supply_s;

    wire high_armed = en_s && ss_s && in_run;
    wire low_armed = en_s && ss_s && in_run;
    wire tpin_armed = !lockout;

    logic exp_high;
    logic exp_low;
    logic exp_tpin;
    logic exp_oc;

    persist_timer #(.LIMIT(fault_latch_pkg::PERSIST_CYCLES)) u_t_high (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .flag(fb_high_s && high_armed),
        .expired(exp_high)
    );
    persist_timer #(.LIMIT(fault_latch_pkg::PERSIST_CYCLES)) u_t_low (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .flag(fb_low_s && low_armed),
        .expired(exp_low)
    );
    persist_timer #(.LIMIT(fault_latch_pkg::PERSIST_CYCLES)) u_t_tpin (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .flag(tpin_s && tpin_armed),
        .expired(exp_tpin)
    );
    persist_timer #(.LIMIT(fault_latch_pkg::PERSIST_CYCLES)) u_t_oc (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .flag(oc_s && in_run),
        .expired(exp_oc)
    );

    wire ss_timeout = (state_reg == fault_latch_pkg::ST_SOFTSTART) &&
                      (ss_count_reg >= fault_latch_pkg::CNT_W'(fault_latch_pkg::SS_TIMEOUT_CYCLES - 1));

    wire sw_force_off = ctrl_reg[fault_latch_pkg::CTRL_FORCE_OFF_BIT];
    // One latch for all latching faults
    wire latch_trip = in_run && (exp_high || exp_low || exp_tpin || exp_oc || ss_timeout);

    logic [fault_latch_pkg::EV_W-1:0] events;
    assign events = {lockout, ot_s && in_run, ss_timeout, exp_oc, exp_tpin, exp_low, exp_high};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fault_latch_pkg::ST_STANDBY: begin
                if (en_s && !lockout && !sw_force_off) begin
                    state_next = fault_latch_pkg::ST_SOFTSTART;
                end
            end
            fault_latch_pkg::ST_SOFTSTART: begin
                if (lockout || !en_s || sw_force_off) begin
                    state_next = fault_latch_pkg::ST_STANDBY;
                end else if (latch_trip) begin
                    state_next = fault_latch_pkg::ST_OFF_LATCH;
                end else if (ss_s) begin
                    state_next = fault_latch_pkg::ST_REGULATE;
                end
            end
            fault_latch_pkg::ST_REGULATE: begin
                if (lockout || !en_s || sw_force_off) begin
                    state_next = fault_latch_pkg::ST_STANDBY;
                end else if (latch_trip) begin
                    state_next = fault_latch_pkg::ST_OFF_LATCH;
                end
            end
            fault_latch_pkg::ST_OFF_LATCH: begin
                if (!en_s) begin
                    state_next = fault_latch_pkg::ST_STANDBY;
                end
            end
            default: state_next = fault_latch_pkg::ST_STANDBY;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= fault_latch_pkg::ST_STANDBY;
            ss_count_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            ss_count_reg <= (state_reg == fault_latch_pkg::ST_SOFTSTART) ? ss_count_reg + 1'b1 : '0;
        end
    end

    // Cause of the last latch, kept until the latch is released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_reg <= '0;
        end else if (clk_en) begin
            if (state_reg == fault_latch_pkg::ST_STANDBY) begin
                cause_reg <= '0;
            end else if (latch_trip) begin
                cause_reg <= cause_reg | events;
            end
        end
    end

    // Cycle-by-cycle current cut, released at the next period start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_cut_reg <= 1'b0;
        end else if (clk_en) begin
            if (oc_s) begin
                oc_cut_reg <= 1'b1;
            end else if (period_s) begin
                oc_cut_reg <= 1'b0;
            end
        end
    end

    wire run_ok = in_run && !ot_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_run <= 1'b0;
            soft_start_run <= 1'b0;
            high_side_on <= 1'b0;
        end else if (clk_en) begin
            converter_run <= run_ok;
            soft_start_run <= in_run;
            high_side_on <= run_ok && on_req_s && !oc_s && !oc_cut_reg;
        end
    end

    // APB decode
    wire apb_access = psel && penable;
    wire apb_wr = apb_access && pwrite;
    wire hit_ctrl = (paddr == fault_latch_pkg::CTRL_OFF);
    wire hit_status = (paddr == fault_latch_pkg::STATUS_OFF);
    wire hit_istat = (paddr == fault_latch_pkg::IRQ_STAT_OFF);
    wire hit_imask = (paddr == fault_latch_pkg::IRQ_MASK_OFF);
    wire hit_any = hit_ctrl || hit_status || hit_istat || hit_imask;

    logic [31:0] status_word;
    assign status_word = {16'h0000, 1'b0, state_reg, 2'b00, in_run, state_reg == fault_latch_pkg::ST_OFF_LATCH,
                          1'b0, cause_reg};

    logic [31:0] read_mux;
    assign read_mux = hit_ctrl ? ctrl_reg :
                      hit_status ? status_word :
                      hit_istat ? {25'h0000000, irq_stat_reg} :
                      hit_imask ? {25'h0000000, irq_mask_reg} : 32'h0000_0000;

    assign pready = 1'b1;
    assign pslverr = apb_access && !hit_any;
    assign prdata = prdata_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            prdata_reg <= read_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= fault_latch_pkg::CTRL_RESET;
            irq_mask_reg <= fault_latch_pkg::IRQ_MASK_RESET[fault_latch_pkg::EV_W-1:0];
        end else if (clk_en && apb_wr) begin
            if (hit_ctrl) begin
                ctrl_reg <= {31'h00000000, pwdata[0]};
            end
            if (hit_imask) begin
                irq_mask_reg <= pwdata[fault_latch_pkg::EV_W-1:0];
            end
        end
    end

    // Sticky events: a set in the same cycle as a write-one clear wins
    wire [fault_latch_pkg::EV_W-1:0] w1c = (apb_wr && hit_istat) ? pwdata[fault_latch_pkg::EV_W-1:0] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else if (clk_en) begin
            irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

/* File: design/fault_latch_pkg.sv */
/*
 Constants, register map and state encodings for the converter fault-latch control.
 Assumes a 40 MHz pclk; time constants are converted to whole cycles here.
*/
`default_nettype none
package fault_latch_pkg;
    localparam int unsigned CLK_HZ = 40000000;
    // Persistence time for the output-high, output-low, timing-pin and over-current faults
    localparam int unsigned PERSIST_US = 500;
    localparam int unsigned PERSIST_CYCLES = (PERSIST_US * (CLK_HZ / 1000000));
    // Soft-start time-out
    localparam int unsigned SS_TIMEOUT_MS = 64;
    localparam int unsigned SS_TIMEOUT_CYCLES = SS_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 32;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [11:0] IRQ_STAT_OFF = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFF = 12'h00C;

    // Control register: bit 0 software force-off, bit 1 timer test freeze not used
    localparam int CTRL_FORCE_OFF_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;

    // Event bit positions (shared by status, interrupt status and mask)
    localparam int EV_OUT_HIGH = 0;
    localparam int EV_OUT_LOW = 1;
    localparam int EV_TIMING_PIN = 2;
    localparam int EV_OVERCURRENT = 3;
    localparam int EV_SS_TIMEOUT = 4;
    localparam int EV_OVERTEMP = 5;
    localparam int EV_LOCKOUT = 6;
    localparam int EV_W = 7;

    // Status register extra bits
    localparam int ST_LATCHED = 8;
    localparam int ST_RUN = 9;
    localparam int ST_STATE_LSB = 12;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_SOFTSTART = 3'b001,
        ST_REGULATE = 3'b011,
        ST_OFF_LATCH = 3'b010
    } seq_state_type;
endpackage
`default_nettype wire

/* File: design/persist_timer.sv */
/*
 Persistence timer: raises expired once its flag has held without a break for LIMIT cycles, and holds it while the flag stays high.
 Assumes the flag is already synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module persist_timer #(
    parameter int unsigned LIMIT = 20000
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Flag and result
    input wire logic flag,
    output logic expired
);
    logic [fault_latch_pkg::CNT_W-1:0] count_reg;
    logic [fault_latch_pkg::CNT_W-1:0] count_next;
    wire at_limit = (count_reg >= fault_latch_pkg::CNT_W'(LIMIT - 1));

    assign count_next = !flag ? '0 : (at_limit ? count_reg : count_reg + 1'b1);
    assign expired = flag && at_limit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (clk_en) begin
            count_reg <= count_next;
        end
    end
endmodule
`default_nettype wire

/* File: design/sync2.sv */
/*
 Two flip-flop synchroniser for a bus of levels from outside the clock domain.
 Assumes each bit changes slowly compared with pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;
    assign q = q_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else if (clk_en) begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end
endmodule
`default_nettype wire

/* File: tb/host_enable_model.sv */
/*
 Host side of the enable pin: drives enable as a level, changed only after a rising edge.
 Assumes the bench asks for on or off through want_on.
*/
`timescale 1ns/1ps
`default_nettype none
module host_enable_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request and pin
    input wire logic want_on,
    output logic enable_pin
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_pin <= 1'b0;
        end else begin
            enable_pin <= want_on;
        end
    end
endmodule
`default_nettype wire

/* File: tb/converter_fault_latch_control_monitor.sv */
/*
 Concurrent checks on the fault-latch control ports.
 Assumes the bind below; pin effects need up to four edges through the synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
module converter_fault_latch_control_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic enable_pin,
    input wire logic supply_ok,
    input wire logic overcurrent,
    input wire logic overtemp_shutdown,
    input wire logic pwm_on_request,
    // Outputs
    input wire logic converter_run,
    input wire logic soft_start_run,
    input wire logic high_side_on
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Six samples cover two sync stages plus the state and output registers
    sequence en_low_s;
        !enable_pin [*6];
    endsequence
    sequence supply_low_s;
        !supply_ok [*6];
    endsequence
    wire access = psel && penable;
    ready_high_a: assert property (pready) else $error("pready low");
    slverr_unmapped_a: assert property (access && paddr > 12'h00F |-> pslverr) else $error("no slave error");
    slverr_mapped_a: assert property (access && paddr[1:0] == 2'h0 && paddr <= 12'h00C |-> !pslverr)
        else $error("slave error on mapped register");
    overtemp_off_a: assert property (overtemp_shutdown [*6] |-> !converter_run)
        else $error("output runs while over temperature");
    enable_off_a: assert property (en_low_s |-> !soft_start_run && !converter_run)
        else $error("runs with enable low");
    lockout_off_a: assert property (supply_low_s |-> !soft_start_run)
        else $error("runs in supply lockout");
    overcurrent_cut_a: assert property (overcurrent [*5] |-> !high_side_on)
        else $error("high side on during over current");
    no_request_a: assert property (!pwm_on_request [*5] |-> !high_side_on) else $error("high side without request");
    run_in_seq_a: assert property (converter_run |-> soft_start_run)
        else $error("output runs outside soft start or regulation");
    // A start is launched by pin levels seen four edges earlier: two sync stages, state, output
    start_cond_a: assert property ($rose(soft_start_run) |-> $past(enable_pin, 4) && $past(supply_ok, 4))
        else $error("start without enable or supply");
endmodule
bind converter_fault_latch_control converter_fault_latch_control_monitor i_converter_fault_latch_control_monitor (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .enable_pin, .supply_ok, .overcurrent,
    .overtemp_shutdown, .pwm_on_request, .converter_run, .soft_start_run, .high_side_on
);
`default_nettype wire

/* File: tb/converter_fault_latch_control_tb.sv */
/*
 Self-checking bench: APB accesses plus pin stimulus, with the host enable model.
 Assumes zero-wait APB and a four-edge pin-to-output delay; persistence counts are full length.
*/
`timescale 1ns/1ps
`default_nettype none
module converter_fault_latch_control_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err, enable_pin, converter_run, soft_start_run, high_side_on, irq;
    logic want_on = 1'b0;
    logic supply_ok = 1'b0;
    logic soft_start_threshold = 1'b0;
    logic [4:0] flt = 5'h00;
    logic pwm_period_start = 1'b0;
    logic pwm_on_request = 1'b0;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    int waits = 0;
    localparam int P = fault_latch_pkg::PERSIST_CYCLES;
    always #12.5 pclk = ~pclk;
    // Switching period of 40 cycles, on request in the first half
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        pwm_period_start <= (cyc % 40) == 0;
        pwm_on_request <= (cyc % 40) < 20;
    end
    converter_fault_latch_control i_converter_fault_latch_control (
        .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .enable_pin, .supply_ok, .soft_start_threshold, .feedback_high(flt[1]), .feedback_low(flt[4]),
        .timing_pin_open_short_fault(flt[2]), .overcurrent(flt[0]), .overtemp_shutdown(flt[3]),
        .pwm_period_start, .pwm_on_request, .converter_run, .soft_start_run, .high_side_on, .irq
    );
    host_enable_model i_host_enable_model (.pclk, .presetn, .want_on, .enable_pin);
    task results;
        if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task st(input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, fault_latch_pkg::STATUS_OFF, 32'h0);
        chk(rd & m, exp);
    endtask
    task hold(input int k, input int n);
        flt[k] <= 1'b1;
        wt(n);
        flt[k] <= 1'b0;
        wt(8);
    endtask
    task release_latch;
        want_on <= 1'b0;
        wt(8);
        st(32'h0000_0000, 32'h0000_7100);
        want_on <= 1'b1;
        wt(8);
        st(32'h0000_3000, 32'h0000_7100);
    endtask
    initial begin
        wt(4);
        presetn <= 1'b1;
        apb(1'b0, fault_latch_pkg::CTRL_OFF, 32'h0);
        chk(rd, fault_latch_pkg::CTRL_RESET);
        apb(1'b0, fault_latch_pkg::IRQ_MASK_OFF, 32'h0);
        chk(rd, fault_latch_pkg::IRQ_MASK_RESET);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h0000_0000);
        supply_ok <= 1'b1;
        want_on <= 1'b1;
        wt(8);
        st(32'h0000_1000, 32'h0000_7000);
        soft_start_threshold <= 1'b1;
        wt(8);
        st(32'h0000_3000, 32'h0000_7000);
        chk({31'h0, converter_run}, 32'h0000_0001);
        flt[3] <= 1'b1;
        wt(8);
        chk({31'h0, converter_run}, 32'h0000_0000);
        flt[3] <= 1'b0;
        wt(8);
        chk({31'h0, converter_run}, 32'h0000_0001);
        flt[0] <= 1'b1;
        wt(P / 2);
        chk({31'h0, high_side_on}, 32'h0000_0000);
        flt[0] <= 1'b0;
        wt(8);
        st(32'h0000_3000, 32'h0000_7100);
        // Cut lasts to the next period start, then the high side follows the request
        while (high_side_on !== 1'b1 && waits < 80) begin
            wt(1);
            waits++;
        end
        chk({31'h0, high_side_on}, 32'h0000_0001);
        hold(0, P + 10);
        st(32'h0000_2108, 32'h0000_710F);
        chk({31'h0, converter_run}, 32'h0000_0000);
        apb(1'b1, fault_latch_pkg::IRQ_MASK_OFF, 32'h0);
        wt(2);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, fault_latch_pkg::IRQ_MASK_OFF, 32'h0000_0008);
        wt(2);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, fault_latch_pkg::IRQ_STAT_OFF, 32'h0000_0008);
        wt(2);
        chk({31'h0, irq}, 32'h0000_0000);
        wt(20);
        st(32'h0000_0100, 32'h0000_0100);
        release_latch;
        hold(1, P + 10);
        st(32'h0000_2101, 32'h0000_710F);
        release_latch;
        hold(2, P + 10);
        st(32'h0000_2104, 32'h0000_710F);
        release_latch;
        hold(4, P + 10);
        st(32'h0000_2102, 32'h0000_710F);
        release_latch;
        supply_ok <= 1'b0;
        wt(8);
        chk({31'h0, soft_start_run}, 32'h0000_0000);
        st(32'h0000_0000, 32'h0000_7000);
        supply_ok <= 1'b1;
        wt(8);
        st(32'h0000_3000, 32'h0000_7000);
        // Software force-off parks the sequencer in standby without latching
        apb(1'b1, fault_latch_pkg::CTRL_OFF, 32'h0000_0001);
        wt(4);
        st(32'h0000_0000, 32'h0000_7100);
        apb(1'b0, fault_latch_pkg::CTRL_OFF, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b1, fault_latch_pkg::CTRL_OFF, 32'h0);
        wt(8);
        st(32'h0000_3000, 32'h0000_7000);
        results;
    end
    initial begin
        // Four full persistence holds plus half of one stay well inside this span
        repeat (5 * P) @(posedge pclk);
        chk(32'h0000_0000, 32'h0000_0001);
        results;
    end
endmodule
`default_nettype wire
